// ---- shared/hidap_map.svh ----
// Purpose: offsets, reset values and counts of the host irq / dma grant port
// Assumes: 7-bit register address, 8-bit data
// Notes: included by the port module
`ifndef HIDAP_MAP_SVH
`define HIDAP_MAP_SVH
`define HIDAP_ADDR_FIFO_A 7'h00
`define HIDAP_ADDR_FIFO_B 7'h40
`define HIDAP_ADDR_IRQ_STATUS_REG 7'h20
`define HIDAP_ADDR_EXTENDED_IRQ_STATUS_REG 7'h24
`define HIDAP_STATUS_RST 8'h00
`define HIDAP_DATA_RST 8'h00
`define HIDAP_FIFO_DEPTH 16
`define HIDAP_RX_BLOCK 5'h08
`endif

// ---- shared/hidap_pkg.sv ----
// Purpose: types of the host irq / dma grant port
// Assumes: nothing
// Notes: used by name, never imported
package hidap_pkg;
  typedef logic [7:0] hidap_byte_t;
  typedef enum logic {hidap_req_idle, hidap_req_burst} hidap_req_t;
endpackage

// ---- hdl/hidap_fifo.sv ----
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are registered
`timescale 1ns/1ps
module hidap_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_q];
  assign count = cnt_q;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(D));
      out_valid <= (cnt_d != '0);
    end
  end
endmodule

// ---- hdl/hidap_port.sv ----
// Purpose: host side irq pin, status registers and per-channel dma grant access
// Assumes: all pins synchronous to clk; strobes act on their falling edge
// Notes: irq pin is open drain: irq_n_o stays low, irq_oe gates it
`timescale 1ns/1ps
`include "hidap_map.svh"
module hidap_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] addr,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dma_grant_chan_a_n,
  input wire logic dma_grant_chan_b_n,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe,
  output logic irq_n_o,
  output logic irq_oe,
  output logic [1:0] rx_dma_request,
  input wire logic [7:0] irq_src,
  input wire logic [7:0] ext_irq_src,
  input wire logic [1:0] rx_valid,
  input wire logic [1:0][7:0] rx_data,
  output logic [1:0] rx_ready,
  output logic [1:0] tx_valid,
  output logic [1:0][7:0] tx_data
);
  logic rd_q;
  logic wr_q;
  logic rd_fall;
  logic wr_fall;
  logic [1:0] gnt;
  logic any_gnt;
  logic reg_sel;
  logic [1:0] pop;
  logic [1:0] addr_fifo;
  logic [1:0][7:0] head;
  logic [1:0][4:0] fcount;
  logic [7:0] irq_status_reg;
  logic [7:0] extended_irq_status_reg;
  logic pend;
  hidap_pkg::hidap_byte_t rdata;

  assign rd_fall = rd_q & ~rd_n;
  assign wr_fall = wr_q & ~wr_n;
  // grants are active low, one per channel, a wins; tied high when unused
  assign gnt = {~dma_grant_chan_b_n & dma_grant_chan_a_n, ~dma_grant_chan_a_n};
  assign any_gnt = |gnt;
  // address decode only counts when no grant is active
  assign reg_sel = ~any_gnt & ~cs_n;
  assign addr_fifo[0] = reg_sel & (addr == `HIDAP_ADDR_FIFO_A);
  assign addr_fifo[1] = reg_sel & (addr == `HIDAP_ADDR_FIFO_B);
  assign pend = (|irq_status_reg) | (|extended_irq_status_reg);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end
    else
    begin
      rd_q <= rd_n;
      wr_q <= wr_n;
    end
  end

  // grant selects the fifo directly, address ignored
  always_comb
  begin
    rdata = `HIDAP_DATA_RST;
    if (gnt[0])
    begin
      rdata = head[0];
    end
    else if (gnt[1])
    begin
      rdata = head[1];
    end
    else
    begin
      case (addr)
        `HIDAP_ADDR_FIFO_A: rdata = head[0];
        `HIDAP_ADDR_FIFO_B: rdata = head[1];
        `HIDAP_ADDR_IRQ_STATUS_REG: rdata = irq_status_reg;
        `HIDAP_ADDR_EXTENDED_IRQ_STATUS_REG: rdata = extended_irq_status_reg;
        default: rdata = `HIDAP_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_o <= `HIDAP_DATA_RST;
      data_oe <= 1'b0;
    end
    else if (rd_fall & (any_gnt | ~cs_n))
    begin
      data_o <= rdata;
      data_oe <= 1'b1;
    end
    else if (rd_n)
    begin
      data_oe <= 1'b0;
    end
  end

  // sticky causes, cleared by reading; a new event wins over the clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_status_reg <= `HIDAP_STATUS_RST;
      extended_irq_status_reg <= `HIDAP_STATUS_RST;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~{8{rd_fall & reg_sel & (addr == `HIDAP_ADDR_IRQ_STATUS_REG)}})
        | irq_src;
      extended_irq_status_reg <= (extended_irq_status_reg
        & ~{8{rd_fall & reg_sel & (addr == `HIDAP_ADDR_EXTENDED_IRQ_STATUS_REG)}}) | ext_irq_src;
    end
  end

  // open drain: level fixed low, only the enable moves
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_n_o <= 1'b0;
      irq_oe <= 1'b0;
    end
    else
    begin
      irq_n_o <= 1'b0;
      irq_oe <= pend;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_valid <= '0;
      tx_data <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // grant is only seen once the dma owns the bus
        tx_valid[i] <= wr_fall & (gnt[i] | addr_fifo[i]);
        if (wr_fall & (gnt[i] | addr_fifo[i]))
        begin
          tx_data[i] <= data_i;
        end
      end
    end
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    hidap_pkg::hidap_req_t st_q;
    logic [4:0] left_q;

    assign pop[c] = rd_fall & (gnt[c] | addr_fifo[c]);

    hidap_fifo #(.W(8), .D(`HIDAP_FIFO_DEPTH)) u_rx_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(rx_valid[c]),
      .in_ready(rx_ready[c]),
      .in_data(rx_data[c]),
      .out_valid(),
      .out_ready(pop[c]),
      .out_data(head[c]),
      .count(fcount[c])
    );

    // request held for a whole block, dropped after the last read falls
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        st_q <= hidap_pkg::hidap_req_idle;
        left_q <= '0;
        rx_dma_request[c] <= 1'b0;
      end
      else
      begin
        case (st_q)
          hidap_pkg::hidap_req_idle:
          begin
            if (fcount[c] >= `HIDAP_RX_BLOCK)
            begin
              st_q <= hidap_pkg::hidap_req_burst;
              left_q <= `HIDAP_RX_BLOCK;
              rx_dma_request[c] <= 1'b1;
            end
          end
          hidap_pkg::hidap_req_burst:
          begin
            if (pop[c])
            begin
              left_q <= left_q - 5'h01;
              if (left_q == 5'h01)
              begin
                st_q <= hidap_pkg::hidap_req_idle;
                rx_dma_request[c] <= 1'b0;
              end
            end
          end
          default:
          begin
            st_q <= hidap_pkg::hidap_req_idle;
            rx_dma_request[c] <= 1'b0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  irq_follow_a: assert property (##1 irq_oe == $past(pend))
    else $error("irq enable does not follow pending causes");
  status_read_a: assert property (rd_fall & reg_sel & (addr == `HIDAP_ADDR_IRQ_STATUS_REG) & ~irq_src[0]
    |=> data_o == $past(irq_status_reg) && !irq_status_reg[0])
    else $error("status read wrong or not cleared");
  irq_never_high_a: assert property (irq_n_o == 1'b0)
    else $error("irq pin driven high");
  chan_grant_a: assert property (wr_fall & gnt[1] & ~gnt[0]
    |=> tx_valid == 2'b10 && tx_data[1] == $past(data_i))
    else $error("grant b did not steer the write to channel b");
  grant_pop_a: assert property (rd_fall & gnt[0] |=> data_o == $past(head[0]) && data_oe)
    else $error("granted read did not return fifo top");
  grant_ignore_addr_a: assert property (wr_fall & ~dma_grant_chan_a_n
    |=> tx_valid == 2'b01)
    else $error("address decoded during grant");
  extended_irq_status_reg_select_a: assert property (rd_fall & reg_sel & (addr == `HIDAP_ADDR_EXTENDED_IRQ_STATUS_REG)
    |=> data_o == $past(extended_irq_status_reg))
    else $error("address select returned wrong register");
  req_hold_a: assert property (rx_dma_request[0] & ~pop[0] |=> rx_dma_request[0])
    else $error("request dropped inside a block");
  req_drop_a: assert property (rx_dma_request[0] & pop[0] & (g_chan[0].left_q == 5'h01)
    |=> !rx_dma_request[0])
    else $error("request not withdrawn after last read");
  irq_release_a: assert property (!pend [*2] |-> !irq_oe)
    else $error("irq held with nothing pending");

  grant_read_c: cover property (rd_fall & gnt[1] ##1 data_oe);
  block_done_c: cover property (rx_dma_request[0] ##1 !rx_dma_request[0]);
  irq_cycle_c: cover property (!irq_oe ##1 irq_oe ##[1:20] !irq_oe);
endmodule

// ---- sim/hidap_host.sv ----
// Purpose: host cpu and dma controller model on the parallel bus
// Assumes: one clock; the bench calls access for every bus cycle
// Notes: irq line carries its pull-up here
`timescale 1ns/1ps
module hidap_host (
  input wire logic clk,
  output logic [6:0] addr,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic dma_grant_chan_a_n,
  output logic dma_grant_chan_b_n,
  output logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic irq_oe,
  output logic irq_line
);
  // pull-up wins whenever nobody pulls low
  assign irq_line = irq_oe ? 1'b0 : 1'b1;
  initial
  begin
    addr = 7'h7F;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    dma_grant_chan_a_n = 1'b1;
    dma_grant_chan_b_n = 1'b1;
    data_i = 8'hFF;
  end
  // sel: 0 chip select, 1 grant a, 2 grant b, 3 nothing
  task automatic access(input logic wr, input logic [1:0] sel, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    data_i <= d;
    cs_n <= (sel != 2'h0);
    dma_grant_chan_a_n <= (sel != 2'h1);
    dma_grant_chan_b_n <= (sel != 2'h2);
    rd_n <= wr;
    wr_n <= !wr;
    repeat (3) @(posedge clk);
    // undriven data bus reads as garbage
    q = data_oe ? data_o : ~data_o;
    cs_n <= 1'b1;
    dma_grant_chan_a_n <= 1'b1;
    dma_grant_chan_b_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    addr <= ~a;
    data_i <= ~d;
  endtask
endmodule

// ---- sim/testbench.sv ----
// Purpose: self-checking bench of the irq pin and dma grant port
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes: host model makes every bus cycle
`timescale 1ns/1ps
`include "hidap_map.svh"
module testbench;
  typedef struct {logic ext; logic [7:0] pat;} hidap_row_t;
  hidap_row_t rows[4] = '{'{1'b0, 8'h01}, '{1'b0, 8'h80}, '{1'b1, 8'h5A}, '{1'b1, 8'hFF}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] irq_src = 8'h00;
  logic [7:0] ext_irq_src = 8'h00;
  logic [1:0] rx_valid = 2'b00;
  logic [1:0][7:0] rx_data = '0;
  logic [6:0] addr;
  logic cs_n, rd_n, wr_n, ga_n, gb_n, data_oe, irq_n_o, irq_oe, irq_line;
  logic [7:0] data_i, data_o, q;
  logic [1:0] rx_dma_request, rx_ready, tx_valid;
  logic [1:0][7:0] tx_data;
  int fail_count = 0;
  int n_checks = 0;
  int tx_seen[2] = '{0, 0};
  int drops = 0;
  logic [1:0] ch;
  logic req_prev = 1'b0;
  always #10 clk = ~clk;
  hidap_host host (.clk(clk), .addr(addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .dma_grant_chan_a_n(ga_n), .dma_grant_chan_b_n(gb_n), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .irq_oe(irq_oe), .irq_line(irq_line));
  hidap_port uut (.clk(clk), .reset(reset), .addr(addr), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .dma_grant_chan_a_n(ga_n), .dma_grant_chan_b_n(gb_n), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .irq_n_o(irq_n_o), .irq_oe(irq_oe),
    .rx_dma_request(rx_dma_request), .irq_src(irq_src), .ext_irq_src(ext_irq_src),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
    begin
      rx_valid[0] <= 1'b1;
      rx_data[0] <= base + 8'(i);
      @(posedge clk);
    end
    rx_valid[0] <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    if (tx_valid[0] === 1'b1) tx_seen[0]++;
    if (tx_valid[1] === 1'b1) tx_seen[1]++;
    if (rx_dma_request[0] === 1'b0 && req_prev === 1'b1) drops++;
    req_prev <= rx_dma_request[0];
    if (!reset) chk({7'h00, irq_n_o}, 8'h00);
  end
  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk({2'b00, rx_dma_request, rx_ready, data_oe, irq_line}, 8'h0D);
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      if (rows[r].ext) ext_irq_src <= rows[r].pat;
      else irq_src <= rows[r].pat;
      @(posedge clk);
      irq_src <= 8'h00;
      ext_irq_src <= 8'h00;
      repeat (3) @(posedge clk);
      chk({7'h00, irq_line}, 8'h00);
      host.access(1'b0, 2'h0, rows[r].ext ? `HIDAP_ADDR_EXTENDED_IRQ_STATUS_REG : `HIDAP_ADDR_IRQ_STATUS_REG, 8'h00, q);
      chk(q, rows[r].pat);
      repeat (3) @(posedge clk);
      chk({7'h00, irq_line}, 8'h01);
    end
    host.access(1'b0, 2'h0, 7'h10, 8'h00, q);
    chk(q, 8'h00);
    // writes by address, then by grant with the other channel's address
    for (int k = 0; k < 4; k++)
    begin
      ch = {1'b0, k[0]};
      host.access(1'b1, k[1] ? 2'(k) - 2'h1 : 2'h0, (k[1] ^ k[0]) ? 7'h40 : 7'h00,
        8'hA0 + 8'(k), q);
      chk(tx_data[ch[0]], 8'hA0 + 8'(k));
    end
    host.access(1'b1, 2'h0, `HIDAP_ADDR_IRQ_STATUS_REG, 8'h55, q);
    chk(8'(tx_seen[0] * 16 + tx_seen[1]), 8'h22);
    @(posedge clk);
    push(7, 8'h30);
    repeat (3) @(posedge clk);
    chk({6'h00, rx_dma_request}, 8'h00);
    push(10, 8'h37);
    repeat (3) @(posedge clk);
    chk({4'h0, rx_dma_request, rx_ready}, 8'h06);
    for (int i = 0; i < 16; i++)
    begin
      if (i % 8 == 7) chk({7'h00, rx_dma_request[0]}, 8'h01);
      host.access(1'b0, 2'h1, `HIDAP_ADDR_IRQ_STATUS_REG, 8'h00, q);
      chk(q, 8'h30 + 8'(i));
    end
    repeat (3) @(posedge clk);
    chk(8'(drops), 8'h02);
    chk({4'h0, rx_dma_request, rx_ready}, 8'h03);
    // mid-run reset with a cause pending
    irq_src <= 8'h04;
    @(posedge clk);
    irq_src <= 8'h00;
    repeat (3) @(posedge clk);
    chk({7'h00, irq_line}, 8'h00);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk({2'b00, rx_dma_request, rx_ready, data_oe, irq_line}, 8'h0D);
    host.access(1'b0, 2'h0, `HIDAP_ADDR_IRQ_STATUS_REG, 8'h00, q);
    chk(q, 8'h00);
    tally_and_finish();
  end
endmodule
